// file: design/asse_pkg.sv
// package for the axis start/stop supervision block
// assumes one 100 MHz clock and a register port driven by the host logic
package asse_pkg;
   // -----------------------------------------------------------------
   // register map (word index = byte address here)
   // -----------------------------------------------------------------
   localparam logic [7:0] ASSE_REG_CTRL = 8'h00;
   localparam logic [7:0] ASSE_REG_NEAR_PASS = 8'h01;
   localparam logic [7:0] ASSE_REG_SHIFT_SPD = 8'h02;
   localparam logic [7:0] ASSE_REG_BACKLASH = 8'h03;
   localparam logic [7:0] ASSE_REG_PULSE_UNIT = 8'h04;
   localparam logic [7:0] ASSE_REG_OVERRIDE = 8'h05;
   localparam logic [7:0] ASSE_REG_DONE_TIME = 8'h06;
   localparam logic [7:0] ASSE_REG_RUN_STATE = 8'h07;
   localparam logic [7:0] ASSE_REG_FAULT = 8'h08;
   localparam logic [7:0] ASSE_REG_WARN = 8'h09;
   localparam logic [7:0] ASSE_REG_IRQ_STAT = 8'h0a;
   localparam logic [7:0] ASSE_REG_IRQ_MASK = 8'h0b;
   localparam logic [7:0] ASSE_REG_RUN_OVR = 8'h0c;
   localparam logic [15:0] ASSE_DEAD_WORD = 16'hdead;
   // ctrl register bits
   localparam int ASSE_CTRL_START = 0;
   localparam int ASSE_CTRL_STOP = 1;
   localparam int ASSE_CTRL_JOG_FWD = 2;
   localparam int ASSE_CTRL_JOG_REV = 3;
   localparam int ASSE_CTRL_ERR_RST = 4;
   localparam int ASSE_CTRL_SPD_CHG = 5;
   // irq bits
   localparam int ASSE_IRQ_FAULT = 0;
   localparam int ASSE_IRQ_WARN = 1;
   localparam int ASSE_IRQ_DONE = 2;
   // -----------------------------------------------------------------
   // codes
   // -----------------------------------------------------------------
   localparam logic [15:0] ASSE_WARN_START_BUSY = 16'h0064; // 100
   localparam logic [15:0] ASSE_WARN_SPD_DECEL = 16'h01f4; // 500
   localparam logic [15:0] ASSE_ERR_UPPER_LIM = 16'h0068; // 104
   localparam logic [15:0] ASSE_ERR_LOWER_LIM = 16'h0069; // 105
   localparam logic [15:0] ASSE_ERR_BACKLASH = 16'h03aa; // 938
   localparam logic [15:0] ASSE_ERR_NEAR_PASS = 16'h03cb; // 971
   localparam logic [15:0] ASSE_ERR_SHIFT_SPD = 16'h03e5; // 997
   localparam logic [15:0] ASSE_CODE_NONE = 16'h0000;
   // run state word values
   localparam logic [15:0] ASSE_RS_IDLE = 16'h0000;
   localparam logic [15:0] ASSE_RS_RUN = 16'h0001;
   localparam logic [15:0] ASSE_RS_DECEL = 16'h0002;
   localparam logic [15:0] ASSE_RS_STOPPED = 16'h0003;
   localparam logic [15:0] ASSE_RS_ERROR = 16'h0004;
   localparam logic [15:0] ASSE_RS_DONE = 16'h0005;
   // reset values
   localparam logic [15:0] ASSE_OVR_RST = 16'h0064; // 100
   localparam logic [15:0] ASSE_DONE_TIME_RST = 16'h012c; // 300
   // -----------------------------------------------------------------
   // timing
   // -----------------------------------------------------------------
   localparam int ASSE_CLK_MHZ = 100;
   localparam int ASSE_TICK_US = 1000;
   localparam int ASSE_TICK_CYC = ASSE_TICK_US * ASSE_CLK_MHZ;
   localparam int ASSE_DECEL_TICKS = 4;
   localparam int ASSE_AUTO_DECEL_LEFT = 8;

   typedef enum logic [2:0] {
      ASSE_IDLE, ASSE_RUN, ASSE_AUTO_DEC, ASSE_STOP_DEC, ASSE_JOG
   } asse_state_t;
endpackage

// file: design/asse_tick_if.sv
// tick interface between the supervisor and its ms divider
// assumes a single clock shared by both ends
`timescale 1ns/10ps
interface asse_tick_if;
   logic tick;
   logic run;
   modport src (output tick, input run);
   modport dst (input tick, output run);
endinterface

// file: design/asse_tick_div.sv
// ms tick divider for the axis supervisor
// assumes mclk_in at 100 MHz; count is a parameter so sims can shorten it
`timescale 1ns/10ps
module asse_tick_div #(
   parameter int TICK_CYC = 100000
) (
   input wire logic mclk_in, // clock
   input wire logic rst_n_in, // async reset, low
   asse_tick_if.src tk // tick out, run in
);
   import asse_pkg::*;
   logic [16:0] cnt_r;
   logic [16:0] cnt_nxt;
   logic wrap;
   assign wrap = (cnt_r == 17'(TICK_CYC - 1));
   assign cnt_nxt = (!tk.run || wrap) ? 17'h0 : cnt_r + 17'h1;
   assign tk.tick = tk.run && wrap;
   always_ff @(posedge mclk_in or negedge rst_n_in) begin
      if (!rst_n_in) cnt_r <= 17'h0;
      else cnt_r <= cnt_nxt;
   end
endmodule

// file: design/asse_axis.sv
// axis start/stop supervision and parameter checks, one axis
// assumes a host register port on mclk_in; limit pins and ready asynchronous
//
// Overview of operation
// - a stop request begins a decelerating stop and the axis stays busy until it ends.
// - a start while busy, even while stopping, is dropped and sets warning 100.
// - a near-pass selection other than 0 or 1 raises error 971.
// - on a rising host ready the shift-speed selection is checked, error 997 if not 0 or 1.
// - a backlash that is negative or above one pulse of travel raises error 938.
// - a jog with the upper or lower limit input inactive is inhibited with error 104 or 105.
// - warning 500 on a speed change only during stop or auto deceleration, motion goes on.
// - an override written during a move takes effect from the next start only.
// - a move ended by a stop request does not give the complete signal.
// - a move ended by an error gives no complete signal and the code is reported.
`timescale 1ns/10ps
module asse_axis #(
   parameter int TICK_CYC = asse_pkg::ASSE_TICK_CYC
) (
   input wire logic mclk_in, // 100 MHz clock
   input wire logic rst_n_in, // async reset, low
   input wire logic [7:0] addr_in, // register word address
   input wire logic [15:0] wdata_in, // write data
   input wire logic wr_in, // write strobe
   input wire logic rd_in, // read strobe
   output logic [15:0] rdata_out, // read data, cycle after rd
   input wire logic host_ready_in, // host ready pin
   input wire logic upper_lim_in, // upper stroke limit, high = ok
   input wire logic lower_lim_in, // lower stroke limit, high = ok
   input wire logic ext_stop_in, // external stop pin
   output logic busy_out, // axis executing
   output logic done_out, // positioning complete pulse
   output logic [15:0] run_ovr_out, // override latched for this move
   output logic irq_out // interrupt, level
);
   import asse_pkg::*;
   default clocking cb @(posedge mclk_in); endclocking
   default disable iff (!rst_n_in);

   // ----------------------------------------------------------------
   // pin synchronisers
   // ----------------------------------------------------------------
   logic [3:0] pin_s1_r, pin_s2_r;
   logic rdy_d_r;
   always_ff @(posedge mclk_in or negedge rst_n_in) begin
      if (!rst_n_in) begin
         pin_s1_r <= 4'h0;
         pin_s2_r <= 4'h0;
         rdy_d_r <= 1'b0;
      end else begin
         pin_s1_r <= {ext_stop_in, lower_lim_in, upper_lim_in, host_ready_in};
         pin_s2_r <= pin_s1_r;
         rdy_d_r <= pin_s2_r[0];
      end
   end
   logic rdy_rise, up_ok, lo_ok, ext_stop;
   assign rdy_rise = pin_s2_r[0] && !rdy_d_r;
   assign up_ok = pin_s2_r[1];
   assign lo_ok = pin_s2_r[2];
   assign ext_stop = pin_s2_r[3];

   // ----------------------------------------------------------------
   // register decode
   // ----------------------------------------------------------------
   logic [15:0] near_pass_r, shift_spd_r, backlash_r, pulse_unit_r, ovr_r;
   logic [15:0] done_time_r, run_ovr_r, fault_r, warn_r, run_state_r;
   logic [2:0] irq_stat_r, irq_mask_r;
   logic wr_ctrl, wr_stat, req_start, req_stop, req_jog, req_rst, req_spd;
   assign wr_ctrl = wr_in && (addr_in == ASSE_REG_CTRL);
   assign wr_stat = wr_in && (addr_in == ASSE_REG_IRQ_STAT);
   assign req_start = wr_ctrl && wdata_in[ASSE_CTRL_START];
   assign req_stop = wr_ctrl && wdata_in[ASSE_CTRL_STOP];
   assign req_jog = wr_ctrl &&
      (wdata_in[ASSE_CTRL_JOG_FWD] || wdata_in[ASSE_CTRL_JOG_REV]);
   assign req_rst = wr_ctrl && wdata_in[ASSE_CTRL_ERR_RST];
   assign req_spd = wr_ctrl && wdata_in[ASSE_CTRL_SPD_CHG];

   always_ff @(posedge mclk_in or negedge rst_n_in) begin
      if (!rst_n_in) begin
         near_pass_r <= 16'h0;
         shift_spd_r <= 16'h0;
         backlash_r <= 16'h0;
         pulse_unit_r <= 16'h1;
         ovr_r <= ASSE_OVR_RST;
         done_time_r <= ASSE_DONE_TIME_RST;
         irq_mask_r <= 3'h0;
      end else if (wr_in) begin
         unique case (addr_in)
            ASSE_REG_NEAR_PASS: near_pass_r <= wdata_in;
            ASSE_REG_SHIFT_SPD: shift_spd_r <= wdata_in;
            ASSE_REG_BACKLASH: backlash_r <= wdata_in;
            ASSE_REG_PULSE_UNIT: pulse_unit_r <= wdata_in;
            ASSE_REG_OVERRIDE: ovr_r <= wdata_in;
            ASSE_REG_DONE_TIME: done_time_r <= wdata_in;
            ASSE_REG_IRQ_MASK: irq_mask_r <= wdata_in[2:0];
            default: ;
         endcase
      end
   end

   // ----------------------------------------------------------------
   // parameter checks
   // ----------------------------------------------------------------
   logic near_bad, shift_bad, back_bad;
   logic [15:0] chk_code;
   assign near_bad = near_pass_r > 16'h1;
   assign shift_bad = rdy_rise && (shift_spd_r > 16'h1);
   // backlash is signed, must lie in 0 .. one pulse of travel
   assign back_bad = backlash_r[15] ||
      (backlash_r > pulse_unit_r);
   assign chk_code = shift_bad ? ASSE_ERR_SHIFT_SPD :
      near_bad ? ASSE_ERR_NEAR_PASS :
      back_bad ? ASSE_ERR_BACKLASH : ASSE_CODE_NONE;

   // ----------------------------------------------------------------
   // axis sequencer
   // ----------------------------------------------------------------
   asse_tick_if tk ();
   asse_tick_div #(.TICK_CYC(TICK_CYC)) u_div (
      .mclk_in(mclk_in),
      .rst_n_in(rst_n_in),
      .tk(tk)
   );
   asse_state_t st_r, st_nxt;
   logic [7:0] move_cnt_r;
   logic [15:0] done_cnt_r;
   logic stop_hit, move_err, jog_bad, start_ok, finish_ok;
   logic [15:0] jog_code;
   assign busy_out = (st_r != ASSE_IDLE);
   assign tk.run = busy_out || (done_cnt_r != 16'h0);
   assign stop_hit = req_stop || ext_stop;
   assign jog_bad = req_jog && (!up_ok || !lo_ok);
   assign jog_code = !up_ok ? ASSE_ERR_UPPER_LIM : ASSE_ERR_LOWER_LIM;
   assign move_err = (chk_code != ASSE_CODE_NONE) && busy_out;
   assign start_ok = req_start && !busy_out && (chk_code == ASSE_CODE_NONE);
   assign finish_ok = (st_r == ASSE_AUTO_DEC) && tk.tick &&
      (move_cnt_r == 8'h0) && !stop_hit && !move_err;

   always_comb begin
      st_nxt = st_r;
      unique case (st_r)
         ASSE_IDLE: begin
            if (start_ok) st_nxt = ASSE_RUN;
            else if (req_jog && !jog_bad) st_nxt = ASSE_JOG;
         end
         ASSE_RUN, ASSE_JOG: begin
            if (move_err) st_nxt = ASSE_IDLE;
            else if (stop_hit) st_nxt = ASSE_STOP_DEC;
            else if (st_r == ASSE_RUN && tk.tick &&
               move_cnt_r == 8'(ASSE_AUTO_DECEL_LEFT)) st_nxt = ASSE_AUTO_DEC;
         end
         ASSE_AUTO_DEC: begin
            if (move_err) st_nxt = ASSE_IDLE;
            else if (stop_hit) st_nxt = ASSE_STOP_DEC;
            else if (finish_ok) st_nxt = ASSE_IDLE;
         end
         ASSE_STOP_DEC: begin
            // still busy until the deceleration finishes
            if (tk.tick && move_cnt_r == 8'h0) st_nxt = ASSE_IDLE;
         end
      endcase
   end

   always_ff @(posedge mclk_in or negedge rst_n_in) begin
      if (!rst_n_in) begin
         st_r <= ASSE_IDLE;
         move_cnt_r <= 8'h0;
      end else begin
         st_r <= st_nxt;
         if (st_nxt == ASSE_STOP_DEC && st_r != ASSE_STOP_DEC)
            move_cnt_r <= 8'(ASSE_DECEL_TICKS);
         else if (start_ok) move_cnt_r <= 8'hff;
         else if (tk.tick && move_cnt_r != 8'h0 && st_r != ASSE_JOG)
            move_cnt_r <= move_cnt_r - 8'h1;
      end
   end

   // override latched only at a start
   always_ff @(posedge mclk_in or negedge rst_n_in) begin
      if (!rst_n_in) run_ovr_r <= ASSE_OVR_RST;
      else if (start_ok) run_ovr_r <= ovr_r;
   end
   assign run_ovr_out = run_ovr_r;

   // complete pulse, only on a normal finish
   always_ff @(posedge mclk_in or negedge rst_n_in) begin
      if (!rst_n_in) done_cnt_r <= 16'h0;
      else if (finish_ok) done_cnt_r <= done_time_r;
      else if (start_ok) done_cnt_r <= 16'h0;
      else if (tk.tick && done_cnt_r != 16'h0)
         done_cnt_r <= done_cnt_r - 16'h1;
   end
   assign done_out = (done_cnt_r != 16'h0);

   // ----------------------------------------------------------------
   // latched codes and run state
   // ----------------------------------------------------------------
   logic [15:0] err_new, warn_new;
   logic spd_warn;
   assign spd_warn = req_spd &&
      (st_r == ASSE_STOP_DEC || st_r == ASSE_AUTO_DEC);
   assign err_new = (chk_code != ASSE_CODE_NONE) ? chk_code :
      jog_bad ? jog_code : ASSE_CODE_NONE;
   assign warn_new = (req_start && busy_out) ? ASSE_WARN_START_BUSY :
      spd_warn ? ASSE_WARN_SPD_DECEL : ASSE_CODE_NONE;

   always_ff @(posedge mclk_in or negedge rst_n_in) begin
      if (!rst_n_in) begin
         fault_r <= ASSE_CODE_NONE;
         warn_r <= ASSE_CODE_NONE;
      end else begin
         // a new code wins over a reset in the same cycle
         if (req_rst) fault_r <= err_new;
         else if (fault_r == ASSE_CODE_NONE) fault_r <= err_new;
         if (warn_new != ASSE_CODE_NONE) warn_r <= warn_new;
         else if (req_rst) warn_r <= ASSE_CODE_NONE;
      end
   end

   always_ff @(posedge mclk_in or negedge rst_n_in) begin
      if (!rst_n_in) run_state_r <= ASSE_RS_IDLE;
      else if (busy_out && move_err) run_state_r <= ASSE_RS_ERROR;
      else if (st_nxt == ASSE_STOP_DEC) run_state_r <= ASSE_RS_DECEL;
      else if (st_r == ASSE_STOP_DEC && st_nxt == ASSE_IDLE)
         run_state_r <= ASSE_RS_STOPPED;
      else if (finish_ok) run_state_r <= ASSE_RS_DONE;
      else if (st_nxt == ASSE_RUN || st_nxt == ASSE_JOG)
         run_state_r <= ASSE_RS_RUN;
   end

   // ----------------------------------------------------------------
   // interrupts and read port
   // ----------------------------------------------------------------
   logic [2:0] irq_set;
   assign irq_set = {finish_ok, warn_new != ASSE_CODE_NONE,
      err_new != ASSE_CODE_NONE};
   always_ff @(posedge mclk_in or negedge rst_n_in) begin
      if (!rst_n_in) irq_stat_r <= 3'h0;
      else irq_stat_r <= irq_set |
         (irq_stat_r & ~(wr_stat ? wdata_in[2:0] : 3'h0));
   end
   assign irq_out = |(irq_stat_r & irq_mask_r);

   logic [15:0] rd_mux;
   assign rd_mux =
      (addr_in == ASSE_REG_NEAR_PASS) ? near_pass_r :
      (addr_in == ASSE_REG_SHIFT_SPD) ? shift_spd_r :
      (addr_in == ASSE_REG_BACKLASH) ? backlash_r :
      (addr_in == ASSE_REG_PULSE_UNIT) ? pulse_unit_r :
      (addr_in == ASSE_REG_OVERRIDE) ? ovr_r :
      (addr_in == ASSE_REG_DONE_TIME) ? done_time_r :
      (addr_in == ASSE_REG_RUN_STATE) ? run_state_r :
      (addr_in == ASSE_REG_FAULT) ? fault_r :
      (addr_in == ASSE_REG_WARN) ? warn_r :
      (addr_in == ASSE_REG_IRQ_STAT) ? {13'h0, irq_stat_r} :
      (addr_in == ASSE_REG_IRQ_MASK) ? {13'h0, irq_mask_r} :
      (addr_in == ASSE_REG_RUN_OVR) ? run_ovr_r :
      (addr_in == ASSE_REG_CTRL) ? 16'h0 : ASSE_DEAD_WORD;
   always_ff @(posedge mclk_in or negedge rst_n_in) begin
      if (!rst_n_in) rdata_out <= 16'h0;
      else if (rd_in) rdata_out <= rd_mux;
   end

   // ----------------------------------------------------------------
   // checks
   // ----------------------------------------------------------------
   property p_stop_busy;
      (busy_out && !move_err && stop_hit && st_r != ASSE_STOP_DEC) |=>
         busy_out [*2];
   endproperty
   a_stop_busy: assert property (p_stop_busy)
      else $error("stop request dropped busy too early");
   property p_start_warn;
      (req_start && busy_out && st_nxt != ASSE_IDLE) |=>
         (warn_r == ASSE_WARN_START_BUSY) && busy_out && $stable(run_ovr_r);
   endproperty
   a_start_warn: assert property (p_start_warn)
      else $error("busy start not flagged with 100");
   property p_near;
      (near_bad && !shift_bad && fault_r == ASSE_CODE_NONE) |=>
         fault_r == ASSE_ERR_NEAR_PASS;
   endproperty
   a_near: assert property (p_near)
      else $error("near pass error 971 missing");
   property p_shift;
      (shift_bad && fault_r == ASSE_CODE_NONE) |=>
         fault_r == ASSE_ERR_SHIFT_SPD;
   endproperty
   a_shift: assert property (p_shift)
      else $error("shift speed error 997 missing");
   property p_back;
      (back_bad && !near_bad && !shift_bad && fault_r == ASSE_CODE_NONE)
         |=> fault_r == ASSE_ERR_BACKLASH;
   endproperty
   a_back: assert property (p_back)
      else $error("backlash error 938 missing");
   property p_jog;
      (jog_bad && !busy_out) |=> !busy_out;
   endproperty
   a_jog: assert property (p_jog)
      else $error("jog moved past an open limit");
   property p_spd;
      (warn_new == ASSE_WARN_SPD_DECEL) |->
         (st_r == ASSE_STOP_DEC || st_r == ASSE_AUTO_DEC) &&
         (st_nxt != ASSE_IDLE || tk.tick || move_err);
   endproperty
   a_spd: assert property (p_spd)
      else $error("warning 500 outside deceleration");
   property p_ovr;
      (busy_out && !start_ok) |=> $stable(run_ovr_r);
   endproperty
   a_ovr: assert property (p_ovr)
      else $error("override changed the running move");
   property p_no_done;
      (st_r == ASSE_STOP_DEC || move_err) && !done_out |=> !done_out;
   endproperty
   a_no_done: assert property (p_no_done)
      else $error("complete raised after stop or error");
   property p_latch;
      (fault_r != ASSE_CODE_NONE && !req_rst) |=> $stable(fault_r);
   endproperty
   a_latch: assert property (p_latch)
      else $error("fault code changed without reset");
   c_done: cover property ($rose(done_out));
   c_stop: cover property (run_state_r == ASSE_RS_STOPPED);
   c_warn: cover property (warn_r == ASSE_WARN_START_BUSY);
   c_irq: cover property (irq_out);
endmodule

// file: test/asse_host_model.sv
// host side model: drives the axis pins and watches the complete pulse
// assumes the bench calls its tasks from one process, off the reset
`timescale 1ns/10ps
module asse_host_model (
   input wire logic mclk_in, // clock
   input wire logic done_in, // complete pulse from the axis
   output logic host_ready_out, // host ready pin
   output logic upper_lim_out, // upper limit, high = ok
   output logic lower_lim_out, // lower limit, high = ok
   output logic ext_stop_out, // external stop, high = stop
   output logic done_seen_out // complete seen since last clear
);
   initial begin
      host_ready_out = 1'b0;
      upper_lim_out = 1'b1;
      lower_lim_out = 1'b1;
      ext_stop_out = 1'b0;
      done_seen_out = 1'b0;
   end
   // host scan catches any pulse of one clock or more
   always @(posedge mclk_in) begin
      if (done_in === 1'b1) begin
         done_seen_out <= 1'b1;
      end
   end
   task set_pins(input logic rdy, input logic up, input logic lo,
                 input logic stp);
      @(posedge mclk_in);
      host_ready_out <= rdy;
      upper_lim_out <= up;
      lower_lim_out <= lo;
      ext_stop_out <= stp;
   endtask
   // waits out any complete pulse still standing
   task clr_done;
      while (done_in === 1'b1) @(posedge mclk_in);
      @(posedge mclk_in);
      done_seen_out <= 1'b0;
   endtask
endmodule

// file: test/tb_axis_start_stop_error_checks.sv
// bench for the axis supervisor: register tasks and directed tests
// assumes a shortened tick of 10 clocks and the host pin model
`timescale 1ns/10ps
module tb_axis_start_stop_error_checks;
   import asse_pkg::*;
   logic mclk_in = 1'b0, rst_n_in = 1'b0, wr_in = 1'b0, rd_in = 1'b0;
   logic [7:0] addr_in = 8'h00;
   logic [15:0] wdata_in = 16'h0000, rdata_out, run_ovr_out;
   logic host_ready_in, upper_lim_in, lower_lim_in, ext_stop_in;
   logic busy_out, done_out, irq_out, done_seen;
   int err_count = 0, samples_checked = 0, pulse_len = 0;
   always #5 mclk_in = ~mclk_in;
   asse_axis #(.TICK_CYC(10)) DUT (.mclk_in(mclk_in), .rst_n_in(rst_n_in),
      .addr_in(addr_in), .wdata_in(wdata_in), .wr_in(wr_in), .rd_in(rd_in),
      .rdata_out(rdata_out), .host_ready_in(host_ready_in),
      .upper_lim_in(upper_lim_in), .lower_lim_in(lower_lim_in),
      .ext_stop_in(ext_stop_in), .busy_out(busy_out), .done_out(done_out),
      .run_ovr_out(run_ovr_out), .irq_out(irq_out));
   asse_host_model HOST (.mclk_in(mclk_in), .done_in(done_out),
      .host_ready_out(host_ready_in), .upper_lim_out(upper_lim_in),
      .lower_lim_out(lower_lim_in), .ext_stop_out(ext_stop_in),
      .done_seen_out(done_seen));
   // -----------------------------------------------------------------
   // access and compare tasks
   // -----------------------------------------------------------------
   task chk(input logic [15:0] got, input logic [15:0] exp);
      samples_checked++;
      if (got !== exp) begin
         err_count++;
         $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask
   task wr(input logic [7:0] a, input logic [15:0] d);
      @(posedge mclk_in);
      wr_in <= 1'b1;
      addr_in <= a;
      wdata_in <= d;
      @(posedge mclk_in);
      wr_in <= 1'b0;
      #1;
   endtask
   task rchk(input logic [7:0] a, input logic [15:0] e);
      @(posedge mclk_in);
      rd_in <= 1'b1;
      addr_in <= a;
      @(posedge mclk_in);
      rd_in <= 1'b0;
      #1;
      chk(rdata_out, e);
   endtask
   task cmd(input int b);
      wr(ASSE_REG_CTRL, 16'h0001 << b);
   endtask
   task wait_idle;
      int n;
      n = 0;
      while (busy_out !== 1'b0 && n < 4000) begin
         @(posedge mclk_in);
         #1;
         n++;
      end
      chk({15'h0000, busy_out}, 16'h0000);
   endtask
   task end_test(input string name);
      $display("test %s done, mismatches so far %0d", name, err_count);
   endtask
   task print_verdict;
      $display("checks %0d mismatches %0d", samples_checked, err_count);
      if (err_count == 0 && samples_checked > 0) begin
         $display("Testbench passed");
      end else begin
         $display("Testbench failed");
      end
      $finish;
   endtask
   // -----------------------------------------------------------------
   // tests
   // -----------------------------------------------------------------
   initial begin
      repeat (4) @(posedge mclk_in);
      rst_n_in <= 1'b1;
      rchk(ASSE_REG_OVERRIDE, ASSE_OVR_RST);
      rchk(ASSE_REG_DONE_TIME, ASSE_DONE_TIME_RST);
      rchk(ASSE_REG_RUN_STATE, ASSE_RS_IDLE);
      rchk(8'h3f, ASSE_DEAD_WORD);
      wr(ASSE_REG_DONE_TIME, 16'h0005);
      wr(ASSE_REG_IRQ_MASK, 16'h0007);
      end_test("reset");
      wr(ASSE_REG_NEAR_PASS, 16'h0002);
      rchk(ASSE_REG_FAULT, ASSE_ERR_NEAR_PASS);
      wr(ASSE_REG_NEAR_PASS, 16'h0000);
      rchk(ASSE_REG_FAULT, ASSE_ERR_NEAR_PASS);
      rchk(ASSE_REG_IRQ_STAT, 16'h0001);
      chk({15'h0000, irq_out}, 16'h0001);
      wr(ASSE_REG_IRQ_STAT, 16'h0007);
      chk({15'h0000, irq_out}, 16'h0000);
      cmd(ASSE_CTRL_ERR_RST);
      rchk(ASSE_REG_FAULT, ASSE_CODE_NONE);
      wr(ASSE_REG_SHIFT_SPD, 16'h0002);
      rchk(ASSE_REG_FAULT, ASSE_CODE_NONE);
      HOST.set_pins(1'b1, 1'b1, 1'b1, 1'b0);
      repeat (5) @(posedge mclk_in);
      rchk(ASSE_REG_FAULT, ASSE_ERR_SHIFT_SPD);
      wr(ASSE_REG_SHIFT_SPD, 16'h0000);
      cmd(ASSE_CTRL_ERR_RST);
      wr(ASSE_REG_BACKLASH, 16'hffff);
      rchk(ASSE_REG_FAULT, ASSE_ERR_BACKLASH);
      wr(ASSE_REG_BACKLASH, 16'h0002);
      cmd(ASSE_CTRL_ERR_RST);
      rchk(ASSE_REG_FAULT, ASSE_ERR_BACKLASH);
      wr(ASSE_REG_BACKLASH, 16'h0001);
      cmd(ASSE_CTRL_ERR_RST);
      rchk(ASSE_REG_FAULT, ASSE_CODE_NONE);
      end_test("params");
      HOST.set_pins(1'b1, 1'b0, 1'b1, 1'b0);
      repeat (4) @(posedge mclk_in);
      cmd(ASSE_CTRL_JOG_FWD);
      chk({15'h0000, busy_out}, 16'h0000);
      rchk(ASSE_REG_FAULT, ASSE_ERR_UPPER_LIM);
      cmd(ASSE_CTRL_ERR_RST);
      HOST.set_pins(1'b1, 1'b1, 1'b0, 1'b0);
      repeat (4) @(posedge mclk_in);
      cmd(ASSE_CTRL_JOG_REV);
      rchk(ASSE_REG_FAULT, ASSE_ERR_LOWER_LIM);
      HOST.set_pins(1'b1, 1'b1, 1'b1, 1'b0);
      cmd(ASSE_CTRL_ERR_RST);
      wr(ASSE_REG_IRQ_STAT, 16'h0007);
      cmd(ASSE_CTRL_JOG_FWD);
      chk({15'h0000, busy_out}, 16'h0001);
      rchk(ASSE_REG_RUN_STATE, ASSE_RS_RUN);
      cmd(ASSE_CTRL_STOP);
      wait_idle;
      rchk(ASSE_REG_RUN_STATE, ASSE_RS_STOPPED);
      end_test("jog limits");
      HOST.clr_done;
      cmd(ASSE_CTRL_START);
      wr(ASSE_REG_OVERRIDE, 16'h0032);
      rchk(ASSE_REG_RUN_OVR, ASSE_OVR_RST);
      cmd(ASSE_CTRL_SPD_CHG);
      rchk(ASSE_REG_WARN, ASSE_CODE_NONE);
      cmd(ASSE_CTRL_STOP);
      chk({15'h0000, busy_out}, 16'h0001);
      rchk(ASSE_REG_RUN_STATE, ASSE_RS_DECEL);
      cmd(ASSE_CTRL_SPD_CHG);
      rchk(ASSE_REG_WARN, ASSE_WARN_SPD_DECEL);
      chk({15'h0000, busy_out}, 16'h0001);
      cmd(ASSE_CTRL_START);
      rchk(ASSE_REG_WARN, ASSE_WARN_START_BUSY);
      chk({15'h0000, irq_out}, 16'h0001);
      wait_idle;
      rchk(ASSE_REG_RUN_STATE, ASSE_RS_STOPPED);
      chk({15'h0000, done_seen}, 16'h0000);
      cmd(ASSE_CTRL_ERR_RST);
      wr(ASSE_REG_IRQ_STAT, 16'h0007);
      end_test("stop and restart");
      cmd(ASSE_CTRL_START);
      rchk(ASSE_REG_RUN_OVR, 16'h0032);
      chk(run_ovr_out, 16'h0032);
      wait_idle;
      while (done_out === 1'b1 && pulse_len < 200) begin
         @(posedge mclk_in);
         #1;
         pulse_len++;
      end
      chk(16'(pulse_len), 16'h0032);
      chk({15'h0000, done_seen}, 16'h0001);
      rchk(ASSE_REG_RUN_STATE, ASSE_RS_DONE);
      end_test("normal move");
      HOST.clr_done;
      cmd(ASSE_CTRL_START);
      wr(ASSE_REG_NEAR_PASS, 16'h0002);
      wait_idle;
      rchk(ASSE_REG_RUN_STATE, ASSE_RS_ERROR);
      rchk(ASSE_REG_FAULT, ASSE_ERR_NEAR_PASS);
      chk({15'h0000, done_seen}, 16'h0000);
      wr(ASSE_REG_NEAR_PASS, 16'h0000);
      cmd(ASSE_CTRL_ERR_RST);
      end_test("error abort");
      HOST.clr_done;
      cmd(ASSE_CTRL_START);
      HOST.set_pins(1'b1, 1'b1, 1'b1, 1'b1);
      repeat (4) @(posedge mclk_in);
      HOST.set_pins(1'b1, 1'b1, 1'b1, 1'b0);
      wait_idle;
      rchk(ASSE_REG_RUN_STATE, ASSE_RS_STOPPED);
      chk({15'h0000, done_seen}, 16'h0000);
      end_test("external stop");
      print_verdict;
   end
   initial begin
      #500000;
      err_count++;
      print_verdict;
   end
endmodule
